// ==== common/ala_pkg.sv ====
// package of constants for the analog limit alarm reporter
package ala_pkg;
	localparam int          DATA_W        = 16;
	localparam int          NUM_CH        = 2;
	localparam logic [15:0] CODE_OVERFLOW = 16'h7FFF;
	localparam logic [15:0] CODE_UNDERFLOW= 16'h8000;
	localparam logic [15:0] VALUE_RESET   = 16'h0000;
	// limit flag doubleword layout
	localparam int          UPPER_BYTE    = 0;
	localparam int          LOWER_BYTE    = 1;
	localparam int          BIT_CH0       = 0;
	localparam int          BIT_CH2       = 1;
	localparam logic [31:0] FLAGS_RESET   = 32'h0000_0000;
	// diagnostic record 0
	localparam int          LOST_BYTE     = 3;
	localparam int          LOST_BIT      = 6;
	localparam logic [31:0] DIAG_RESET    = 32'h0000_0000;
	typedef enum logic [2:0] {
		ALA_NOMINAL   = 3'b000,
		ALA_DRIVE     = 3'b001,
		ALA_OVERFLOW  = 3'b010,
		ALA_UNDERFLOW = 3'b011
	} ala_class_e;
endpackage : ala_pkg

// ==== hdl/ala_channel.sv ====
// one channel: saturation substitution and limit comparison
`timescale 1ns/1ns
module ala_channel #(
	parameter int DW = 16
) (
	// measurement
	input  wire logic signed [DW-1:0] measValue,
	input  wire logic                 isOverflow,
	input  wire logic                 isUnderflow,
	// limits
	input  wire logic signed [DW-1:0] highLimit,
	input  wire logic signed [DW-1:0] lowLimit,
	// results
	output logic        [DW-1:0]      reportValue,
	output logic                      aboveHigh,
	output logic                      belowLow
);
	always_comb begin
		if (isOverflow) begin
			reportValue = DW'(ala_pkg::CODE_OVERFLOW);
		end else if (isUnderflow) begin
			reportValue = DW'(ala_pkg::CODE_UNDERFLOW);
		end else begin
			reportValue = measValue;
		end
	end
	assign aboveHigh = measValue > highLimit;
	assign belowLow  = measValue < lowLimit;
endmodule : ala_channel

// ==== hdl/ala_reporter.sv ====
// range and limit supervision with diagnostics and interrupt requests
// Operation
// - byte 0: upper limit exceeded, channels 0, 2
// - byte 1: lower limit violated, channels 0, 2
// - repeat interrupt while busy sets lost bit
// - nominal or drive region: value passes, quiet
// - overflow 7FFFh, underflow 8000h, gated diag interrupt
// - range error indicator and diag entry need group diagnostics
// - limit breach transmits value, gated process interrupt
// - missing supply always lights indicator
// - limit interrupts only channels 0, 2, off default
`timescale 1ns/1ns
module ala_reporter #(
	parameter int DW = 16
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          rst_n,
	// measurements, index 0 is channel 0, index 1 is channel 2
	input  wire logic [DW-1:0] measValue0,
	input  wire logic [DW-1:0] measValue2,
	input  wire logic [1:0]    overflowIn,
	input  wire logic [1:0]    underflowIn,
	input  wire logic          sampleStrobe,
	// configuration
	input  wire logic [DW-1:0] highLimit0,
	input  wire logic [DW-1:0] lowLimit0,
	input  wire logic [DW-1:0] highLimit2,
	input  wire logic [DW-1:0] lowLimit2,
	input  wire logic [1:0]    procIrqEnable,
	input  wire logic          diagIrqEnable,
	input  wire logic          groupDiagEnable,
	// supply monitor pin
	input  wire logic          supplyOk,
	// handler state from controller
	input  wire logic          procHandlerBusy,
	input  wire logic          diagClear,
	// results
	output logic [DW-1:0]      reportValue0_ff,
	output logic [DW-1:0]      reportValue2_ff,
	output logic [31:0]        limitFlags_ff,
	output logic [31:0]        diagRecord_ff,
	output logic               diagEntry_ff,
	output logic               groupErrorIndicator_ff,
	output logic               diagIrq_ff,
	output logic               procIrq_ff
);
	logic [DW-1:0] repVal [2];
	logic [1:0]    above;
	logic [1:0]    below;
	logic          supplyMeta_ff;
	logic          supplySync_ff;
	logic [1:0]    rangeErr;
	logic [1:0]    limitHit;
	logic [1:0]    lastHit_ff;

	ala_channel #(.DW(DW)) u_ch0 (
		.measValue  (measValue0),
		.isOverflow (overflowIn[0]),
		.isUnderflow(underflowIn[0]),
		.highLimit  (highLimit0),
		.lowLimit   (lowLimit0),
		.reportValue(repVal[0]),
		.aboveHigh  (above[0]),
		.belowLow   (below[0])
	);
	ala_channel #(.DW(DW)) u_ch2 (
		.measValue  (measValue2),
		.isOverflow (overflowIn[1]),
		.isUnderflow(underflowIn[1]),
		.highLimit  (highLimit2),
		.lowLimit   (lowLimit2),
		.reportValue(repVal[1]),
		.aboveHigh  (above[1]),
		.belowLow   (below[1])
	);

	assign rangeErr = overflowIn | underflowIn;
	// limit events only on valid values of enabled channels
	assign limitHit = (above | below) & ~rangeErr & procIrqEnable;

	// supply pin synchroniser, resets to supply present so no false alarm follows reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			supplyMeta_ff <= 1'b1;
			supplySync_ff <= 1'b1;
		end else begin
			supplyMeta_ff <= supplyOk;
			supplySync_ff <= supplyMeta_ff;
		end
	end

	// transmitted values
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reportValue0_ff <= DW'(ala_pkg::VALUE_RESET);
			reportValue2_ff <= DW'(ala_pkg::VALUE_RESET);
		end else if (sampleStrobe) begin
			reportValue0_ff <= repVal[0];
			reportValue2_ff <= repVal[1];
		end
	end

	// limit flag doubleword, bytes 2 and 3 stay zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			limitFlags_ff <= ala_pkg::FLAGS_RESET;
		end else if (sampleStrobe) begin
			limitFlags_ff <= ala_pkg::FLAGS_RESET;
			limitFlags_ff[ala_pkg::UPPER_BYTE*8+ala_pkg::BIT_CH0] <= above[0] & ~rangeErr[0];
			limitFlags_ff[ala_pkg::UPPER_BYTE*8+ala_pkg::BIT_CH2] <= above[1] & ~rangeErr[1];
			limitFlags_ff[ala_pkg::LOWER_BYTE*8+ala_pkg::BIT_CH0] <= below[0] & ~rangeErr[0];
			limitFlags_ff[ala_pkg::LOWER_BYTE*8+ala_pkg::BIT_CH2] <= below[1] & ~rangeErr[1];
		end
	end

	// process interrupt and lost detection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			procIrq_ff <= 1'b0;
			lastHit_ff <= 2'b00;
		end else begin
			procIrq_ff <= sampleStrobe && (|limitHit) && !procHandlerBusy;
			if (sampleStrobe && (|limitHit)) begin
				lastHit_ff <= limitHit;
			end
		end
	end

	// diagnostic record and entry, set wins over clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			diagRecord_ff <= ala_pkg::DIAG_RESET;
			diagEntry_ff  <= 1'b0;
		end else begin
			if (diagClear) begin
				diagRecord_ff <= ala_pkg::DIAG_RESET;
				diagEntry_ff  <= 1'b0;
			end
			if (sampleStrobe && procHandlerBusy && |(limitHit & lastHit_ff)) begin
				diagRecord_ff[ala_pkg::LOST_BYTE*8+ala_pkg::LOST_BIT] <= 1'b1;
			end
			if (sampleStrobe && groupDiagEnable && |rangeErr) begin
				diagEntry_ff <= 1'b1;
			end
		end
	end

	// diagnostic interrupt pulse
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			diagIrq_ff <= 1'b0;
		end else begin
			diagIrq_ff <= sampleStrobe && diagIrqEnable && |rangeErr;
		end
	end

	// group error indicator
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			groupErrorIndicator_ff <= 1'b0;
		end else begin
			groupErrorIndicator_ff <= !supplySync_ff || (groupDiagEnable && |rangeErr);
		end
	end

	property p_overflow_code;
		@(posedge clock) disable iff (!rst_n)
		sampleStrobe && overflowIn[0] |=> reportValue0_ff == ala_pkg::CODE_OVERFLOW;
	endproperty
	a_overflow_code: assert property (p_overflow_code) else $error("overflow code wrong");

	property p_underflow_code;
		@(posedge clock) disable iff (!rst_n)
		sampleStrobe && underflowIn[1] && !overflowIn[1] |=> reportValue2_ff == ala_pkg::CODE_UNDERFLOW;
	endproperty
	a_underflow_code: assert property (p_underflow_code) else $error("underflow code wrong");

	property p_pass_value;
		@(posedge clock) disable iff (!rst_n)
		sampleStrobe && !rangeErr[0] |=> reportValue0_ff == $past(measValue0);
	endproperty
	a_pass_value: assert property (p_pass_value) else $error("value not passed");

	property p_upper_flag;
		@(posedge clock) disable iff (!rst_n)
		sampleStrobe |=> limitFlags_ff[ala_pkg::UPPER_BYTE*8+ala_pkg::BIT_CH2] == $past(above[1] & ~rangeErr[1]);
	endproperty
	a_upper_flag: assert property (p_upper_flag) else $error("upper flag wrong");

	property p_lower_flag;
		@(posedge clock) disable iff (!rst_n)
		sampleStrobe |=> limitFlags_ff[ala_pkg::LOWER_BYTE*8+ala_pkg::BIT_CH0] == $past(below[0] & ~rangeErr[0]);
	endproperty
	a_lower_flag: assert property (p_lower_flag) else $error("lower flag wrong");

	property p_reserved_zero;
		@(posedge clock) disable iff (!rst_n)
		limitFlags_ff[31:16] == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bytes nonzero");

	property p_diag_gate;
		@(posedge clock) disable iff (!rst_n)
		diagIrq_ff |-> $past(diagIrqEnable && sampleStrobe);
	endproperty
	a_diag_gate: assert property (p_diag_gate) else $error("diag interrupt not enabled");

	property p_proc_gate;
		@(posedge clock) disable iff (!rst_n)
		procIrq_ff |-> $past(|procIrqEnable);
	endproperty
	a_proc_gate: assert property (p_proc_gate) else $error("process interrupt not enabled");

	property p_supply_led;
		@(posedge clock) disable iff (!rst_n)
		!supplyOk [*3] |=> groupErrorIndicator_ff;
	endproperty
	a_supply_led: assert property (p_supply_led) else $error("indicator off without supply");

	property p_entry_gate;
		@(posedge clock) disable iff (!rst_n)
		$rose(diagEntry_ff) |-> $past(groupDiagEnable);
	endproperty
	a_entry_gate: assert property (p_entry_gate) else $error("entry without group diagnostics");

	property p_lost_bit;
		@(posedge clock) disable iff (!rst_n)
		sampleStrobe && procHandlerBusy && |(limitHit & lastHit_ff) |=> diagRecord_ff[ala_pkg::LOST_BYTE*8+ala_pkg::LOST_BIT];
	endproperty
	a_lost_bit: assert property (p_lost_bit) else $error("lost interrupt not flagged");
endmodule : ala_reporter

// ==== tb/ala_cpu_model.sv ====
// controller side model: process handler busy time and diagnostic clear
`timescale 1ns/1ns
module ala_cpu_model (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// requests
	input  wire logic       procIrq,
	input  wire logic [7:0] holdCycles,
	input  wire logic       clearReq,
	// handler state
	output logic            procHandlerBusy,
	output logic            diagClear
);
	logic [7:0] cnt_ff;
	// handler stays busy after each process interrupt
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) cnt_ff <= 8'h00;
		else if (procIrq) cnt_ff <= holdCycles;
		else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
	end
	assign procHandlerBusy = (cnt_ff != 8'h00);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) diagClear <= 1'b0;
		else diagClear <= clearReq;
	end
endmodule : ala_cpu_model

// ==== tb/ala_reporter_test.sv ====
// self-checking bench for the analog limit alarm reporter
`timescale 1ns/1ns
module ala_reporter_test;
	typedef struct {logic [15:0] m0, m2; logic [1:0] ov, un; logic [15:0] r0, r2; logic [31:0] fl; logic di, pi, gi;} ala_row_s;
	ala_row_s rows [6] = '{
		'{16'h0010, 16'hFFF0, 2'h0, 2'h0, 16'h0010, 16'hFFF0, 32'h0000_0000, 1'b0, 1'b0, 1'b0},
		'{16'h0200, 16'h0010, 2'h0, 2'h0, 16'h0200, 16'h0010, 32'h0000_0001, 1'b0, 1'b1, 1'b0},
		'{16'hFE00, 16'h0200, 2'h0, 2'h0, 16'hFE00, 16'h0200, 32'h0000_0102, 1'b0, 1'b1, 1'b0},
		'{16'h0010, 16'hFE00, 2'h0, 2'h0, 16'h0010, 16'hFE00, 32'h0000_0200, 1'b0, 1'b1, 1'b0},
		'{16'h0010, 16'h0010, 2'h1, 2'h0, 16'h7FFF, 16'h0010, 32'h0000_0000, 1'b1, 1'b0, 1'b1},
		'{16'h0010, 16'h0010, 2'h0, 2'h2, 16'h0010, 16'h8000, 32'h0000_0000, 1'b1, 1'b0, 1'b1}};
	logic        clock = 1'b0, rst_n = 1'b0, sampleStrobe = 1'b0, supplyOk = 1'b1, clearReq = 1'b0;
	logic        diagIrqEnable = 1'b1, groupDiagEnable = 1'b1, procHandlerBusy, diagClear;
	logic [15:0] measValue0 = 16'h0000, measValue2 = 16'h0000, reportValue0_ff, reportValue2_ff;
	logic [15:0] highLimit0 = 16'h0064, highLimit2 = 16'h0064, lowLimit0 = 16'hFF9C, lowLimit2 = 16'hFF9C;
	logic [1:0]  overflowIn = 2'h0, underflowIn = 2'h0, procIrqEnable = 2'h3;
	logic [31:0] limitFlags_ff, diagRecord_ff;
	logic        diagEntry_ff, groupErrorIndicator_ff, diagIrq_ff, procIrq_ff;
	logic [7:0]  holdCycles = 8'h01;
	int          err_count = 0, n_compared = 0, cyc = 0;
	ala_reporter #(.DW(16)) dut_u (.clock, .rst_n, .measValue0, .measValue2, .overflowIn, .underflowIn,
		.sampleStrobe, .highLimit0, .lowLimit0, .highLimit2, .lowLimit2, .procIrqEnable, .diagIrqEnable,
		.groupDiagEnable, .supplyOk, .procHandlerBusy, .diagClear, .reportValue0_ff, .reportValue2_ff,
		.limitFlags_ff, .diagRecord_ff, .diagEntry_ff, .groupErrorIndicator_ff, .diagIrq_ff, .procIrq_ff);
	ala_cpu_model cpu_u (.clock, .rst_n, .procIrq(procIrq_ff), .holdCycles, .clearReq, .procHandlerBusy,
		.diagClear);
	initial forever #5 clock = ~clock;
	task automatic wrap_up;
		if (err_count == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: word %h, want %h", $time, got, exp);
		end
	endtask : chk_w
	task automatic chk_b(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: flag %b, want %b", $time, got, exp);
		end
	endtask : chk_b
	// one strobed sample set, returns where the answer is settled
	task automatic strobe(input logic [15:0] a, input logic [15:0] b, input logic [1:0] o, input logic [1:0] u);
		@(posedge clock);
		measValue0 <= a;
		measValue2 <= b;
		overflowIn <= o;
		underflowIn <= u;
		sampleStrobe <= 1'b1;
		@(posedge clock);
		sampleStrobe <= 1'b0;
		@(negedge clock);
	endtask : strobe
	task automatic clr;
		@(posedge clock);
		clearReq <= 1'b1;
		@(posedge clock);
		clearReq <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : clr
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (15) @(posedge clock);
		@(negedge clock);
		chk_w({limitFlags_ff[15:0], reportValue0_ff | reportValue2_ff}, 32'h0);
		chk_w({diagRecord_ff[31:4], diagEntry_ff, groupErrorIndicator_ff, diagIrq_ff, procIrq_ff}, 32'h0);
		@(posedge clock);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			strobe(rows[i].m0, rows[i].m2, rows[i].ov, rows[i].un);
			chk_w({reportValue0_ff, reportValue2_ff}, {rows[i].r0, rows[i].r2});
			chk_w(limitFlags_ff, rows[i].fl);
			chk_b(diagIrq_ff, rows[i].di);
			chk_b(procIrq_ff, rows[i].pi);
			chk_b(groupErrorIndicator_ff, rows[i].gi);
			repeat (3) @(posedge clock);
		end
		@(negedge clock);
		chk_b(diagEntry_ff, 1'b1);
		@(posedge clock);
		groupDiagEnable <= 1'b0;
		diagIrqEnable <= 1'b0;
		procIrqEnable <= 2'h0;
		supplyOk <= 1'b0;
		clr();
		@(negedge clock);
		chk_b(groupErrorIndicator_ff, 1'b1);
		@(posedge clock);
		supplyOk <= 1'b1;
		clr();
		strobe(16'h0010, 16'h0200, 2'h1, 2'h0);
		chk_w({reportValue0_ff, limitFlags_ff[15:0]}, 32'h7FFF_0002);
		chk_w({diagIrq_ff, procIrq_ff, diagEntry_ff, groupErrorIndicator_ff}, 32'h0);
		@(posedge clock);
		procIrqEnable <= 2'h1;
		strobe(16'h0010, 16'h0200, 2'h0, 2'h0);
		chk_b(procIrq_ff, 1'b0);
		@(posedge clock);
		procIrqEnable <= 2'h3;
		holdCycles <= 8'h14;
		strobe(16'h0200, 16'h0010, 2'h0, 2'h0);
		chk_b(procIrq_ff, 1'b1);
		strobe(16'h0200, 16'h0010, 2'h0, 2'h0);
		chk_b(procIrq_ff, 1'b0);
		chk_w(diagRecord_ff, 32'h4000_0000);
		wrap_up();
	end
endmodule : ala_reporter_test
